// File: rtl/rion_flag_bank.sv
// per-slave participation and communication error flags, one direction
// assumes at most one exchange report per clock
`timescale 1ns/10ps
module rion_flag_bank #(
   parameter int N = 16
) (
   // clock and reset
   input  wire logic         clock,
   input  wire logic         resetn,
   // events
   input  wire logic         clear,
   input  wire logic         hit,
   input  wire logic         ok,
   input  wire logic [3:0]   node,
   // flags
   output logic [N-1:0]      part,
   output logic [N-1:0]      err
);
   typedef struct packed {
      logic [N-1:0] part;
      logic [N-1:0] err;
   } rion_flags_t;

   rion_flags_t s_q, s_d;

   // ----------------------------------------------------------------
   // next state: clear first so that a same-cycle event wins
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      if (clear) begin
         s_d = '0;
      end
      if (hit) begin
         if (ok) begin
            s_d.part[node] = 1'b1;
            s_d.err[node]  = 1'b0;
         end else if (s_d.part[node]) begin
            s_d.err[node]  = 1'b1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign part = s_q.part;
   assign err  = s_q.err;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   part_sticky_a: assert property (
      @(posedge clock) disable iff (!resetn)
      (|($past(part) & ~part)) |-> $past(clear))
      else $error("participation bit fell without clear");
   part_set_a: assert property (
      @(posedge clock) disable iff (!resetn)
      (hit && ok) |=> part[$past(node)] && !err[$past(node)])
      else $error("good exchange did not set participation");
   flag_clear_a: assert property (
      @(posedge clock) disable iff (!resetn)
      (clear && !hit) |=> (part == '0) && (err == '0))
      else $error("restart did not clear flags");
   err_release_a: assert property (
      @(posedge clock) disable iff (!resetn)
      (hit && !ok && part[node] && !clear) |=> err[$past(node)] ##1 err[$past(node, 2)]
         || $past(clear)
         || $past(hit && ok))
      else $error("released slave lost its error bit");
   err_needs_part_a: assert property (
      @(posedge clock) disable iff (!resetn)
      (err & ~part) == '0)
      else $error("error bit without participation");
endmodule

// File: rtl/rion_node_map.sv
// remote i/o master node map: slave words, flags and axi4-lite registers
// assumes the network scanner reports one slave exchange per clock
//
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module rion_node_map
   import rion_pkg::*;
(
   // clock and reset
   input  wire logic                 clock,
   input  wire logic                 resetn,
   // straps
   input  wire logic                 rangeSel,
   input  wire logic [3:0]           unitNum,
   // slave exchange reports
   input  wire logic                 exValid,
   input  wire logic                 exInput,
   input  wire logic [3:0]           exNode,
   input  wire rion_pkg::rion_width_t exWidth,
   input  wire logic                 exOk,
   input  wire logic [15:0]          exInData,
   output logic                      exOutValid,
   output logic [15:0]               exOutData,
   // axi4-lite write
   input  wire logic [7:0]           awaddr,
   input  wire logic                 awvalid,
   output logic                      awready,
   input  wire logic [31:0]          wdata,
   input  wire logic [3:0]           wstrb,
   input  wire logic                 wvalid,
   output logic                      wready,
   output logic [1:0]                bresp,
   output logic                      bvalid,
   input  wire logic                 bready,
   // axi4-lite read
   input  wire logic [7:0]           araddr,
   input  wire logic                 arvalid,
   output logic                      arready,
   output logic [31:0]               rdata,
   output logic [1:0]                rresp,
   output logic                      rvalid,
   input  wire logic                 rready
);
   import rion_pkg::*;

   typedef enum logic {RION_IDLE, RION_RESP} rion_phase_t;

   typedef struct packed {
      rion_phase_t                   wPh;
      rion_phase_t                   rPh;
      logic [1:0]                    bResp;
      logic [1:0]                    rResp;
      logic [31:0]                   rData;
      logic                          captured;
      logic                          range16;
      logic [3:0]                    unit;
      logic                          restart;
      logic                          exDone;
      logic [15:0]                   exOut;
      logic [RION_WORDS-1:0][15:0]   inWord;
      logic [RION_WORDS-1:0][15:0]   outWord;
   } rion_state_t;

   rion_state_t                      s_q, s_d;
   logic [1:0][RION_NODES-1:0]       part;
   logic [1:0][RION_NODES-1:0]       err;
   logic                             unitErr;
   logic                             accept;
   logic                             good;
   logic [2:0]                       wIdx;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a[1:0] == 2'h0) && ((a <= RION_OFS_ERRI) ||
               (a[7:5] == RION_OFS_INW[7:5]) || (a[7:5] == RION_OFS_OUTW[7:5]));
   endfunction

   // even node sits in the high byte, odd node in the low byte
   function automatic logic [15:0] placeIn(input logic [15:0] w, input logic odd,
                                            input rion_width_t wd, input logic [15:0] d);
      logic [7:0] b;
      b = (wd == RION_PT4) ? {4'h0, d[3:0]} : d[7:0];
      placeIn = w;
      if (wd == RION_PT16) begin
         placeIn = d;
      end else if (odd) begin
         placeIn[7:0] = b;
      end else begin
         placeIn[15:8] = b;
      end
   endfunction

   function automatic logic [15:0] takeOut(input logic [15:0] w, input logic odd,
                                            input rion_width_t wd);
      logic [7:0] b;
      b = odd ? w[7:0] : w[15:8];
      if (wd == RION_PT16) begin
         takeOut = w;
      end else if (wd == RION_PT4) begin
         takeOut = {12'h000, b[3:0]};
      end else begin
         takeOut = {8'h00, b};
      end
   endfunction

   // ----------------------------------------------------------------
   // exchange qualification
   // ----------------------------------------------------------------
   assign unitErr = s_q.range16 && (s_q.unit > RION_UNIT_MAX16);
   assign accept  = exValid && s_q.captured && !unitErr
                    && (s_q.range16 || !exNode[3]);
   assign good    = accept && exOk;
   assign wIdx    = exNode[3:1];

   // ----------------------------------------------------------------
   // participation and error flags, output side [0] and input side [1]
   // ----------------------------------------------------------------
   for (genvar g = 0; g < 2; g++) begin : gBank
      rion_flag_bank #(.N(RION_NODES)) uBank (
         .clock  (clock),
         .resetn (resetn),
         .clear  (s_q.restart),
         .hit    (accept && (exInput == (g == 1))),
         .ok     (exOk),
         .node   (exNode),
         .part   (part[g]),
         .err    (err[g])
      );
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d         = s_q;
      s_d.restart = 1'b0;
      s_d.exDone  = accept && !exInput;
      if (!s_q.captured) begin
         s_d.captured = 1'b1;
         s_d.range16  = rangeSel;
         s_d.unit     = unitNum;
      end
      // slave data moves only on a good exchange, which also sets participation
      if (good && exInput) begin
         s_d.inWord[wIdx] = placeIn(s_q.inWord[wIdx], exNode[0], exWidth, exInData);
      end
      if (accept && !exInput) begin
         s_d.exOut = good ? takeOut(s_q.outWord[wIdx], exNode[0], exWidth)
                          : RION_RST_WORD;
      end
      // write channel: both address and data must be present
      case (s_q.wPh)
         RION_IDLE: begin
            if (awvalid && wvalid) begin
               s_d.wPh   = RION_RESP;
               s_d.bResp = mapped(awaddr) ? RION_OKAY : RION_SLVERR;
               if (awaddr == RION_OFS_CTRL && wstrb[0]) begin
                  s_d.restart = wdata[RION_CTRL_RESTART];
               end
               if (mapped(awaddr) && awaddr[7:5] == RION_OFS_OUTW[7:5]) begin
                  if (wstrb[0]) begin
                     s_d.outWord[awaddr[4:2]][7:0] = wdata[7:0];
                  end
                  if (wstrb[1]) begin
                     s_d.outWord[awaddr[4:2]][15:8] = wdata[15:8];
                  end
               end
            end
         end
         RION_RESP: begin
            if (bready) begin
               s_d.wPh = RION_IDLE;
            end
         end
         default: s_d.wPh = RION_IDLE;
      endcase
      // read channel
      case (s_q.rPh)
         RION_IDLE: begin
            if (arvalid) begin
               s_d.rPh   = RION_RESP;
               s_d.rResp = mapped(araddr) ? RION_OKAY : RION_SLVERR;
               s_d.rData = 32'h0000_0000;
               if (!mapped(araddr)) begin
                  s_d.rData = 32'h0000_0000;
               end else if (araddr[7:5] == RION_OFS_INW[7:5]) begin
                  s_d.rData[15:0] = s_q.inWord[araddr[4:2]];
               end else if (araddr[7:5] == RION_OFS_OUTW[7:5]) begin
                  s_d.rData[15:0] = s_q.outWord[araddr[4:2]];
               end else begin
                  case (araddr)
                     RION_OFS_STATUS: begin
                        s_d.rData[RION_ST_RANGE16] = s_q.range16;
                        s_d.rData[RION_ST_UNITERR] = unitErr;
                        s_d.rData[RION_ST_READY]   = s_q.captured;
                     end
                     RION_OFS_INFO: begin
                        s_d.rData[8:0] = s_q.range16 ? RION_POINTS_16 : RION_POINTS_8;
                        s_d.rData[RION_INFO_WORDS+:5] =
                           s_q.range16 ? RION_WORDS_16 : RION_WORDS_8;
                     end
                     RION_OFS_PARTO: s_d.rData[15:0] = part[0];
                     RION_OFS_PARTI: s_d.rData[15:0] = part[1];
                     RION_OFS_ERRO:  s_d.rData[15:0] = err[0];
                     RION_OFS_ERRI:  s_d.rData[15:0] = err[1];
                     default:        s_d.rData = 32'h0000_0000;
                  endcase
               end
            end
         end
         RION_RESP: begin
            if (rready) begin
               s_d.rPh = RION_IDLE;
            end
         end
         default: s_d.rPh = RION_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         s_q <= '{wPh: RION_IDLE, rPh: RION_IDLE, bResp: RION_OKAY, rResp: RION_OKAY,
                  rData: 32'h0000_0000, captured: 1'b0, range16: 1'b0, unit: 4'h0,
                  restart: 1'b0, exDone: 1'b0, exOut: RION_RST_WORD,
                  inWord: '0, outWord: '0};
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign awready    = (s_q.wPh == RION_IDLE) && awvalid && wvalid;
   assign wready     = awready;
   assign bvalid     = (s_q.wPh == RION_RESP);
   assign bresp      = s_q.bResp;
   assign arready    = (s_q.rPh == RION_IDLE);
   assign rvalid     = (s_q.rPh == RION_RESP);
   assign rdata      = s_q.rData;
   assign rresp      = s_q.rResp;
   assign exOutValid = s_q.exDone;
   assign exOutData  = s_q.exOut;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   unit_reject_a: assert property (
      @(posedge clock) disable iff (!resetn)
      (s_q.range16 && s_q.unit > RION_UNIT_MAX16) |=> !exOutValid)
      else $error("exchange served with a bad unit number");
   narrow_range_a: assert property (
      @(posedge clock) disable iff (!resetn)
      (exValid && !s_q.range16 && exNode[3]) |=> !exOutValid && $stable(s_q.inWord))
      else $error("node above seven served in eight-node range");
   even_nibble_a: assert property (
      @(posedge clock) disable iff (!resetn)
      (good && exInput && exWidth == RION_PT4 && !exNode[0]) |=>
         s_q.inWord[$past(wIdx)][15:12] == 4'h0)
      else $error("four-point even node wrote the unused nibble");
   odd_nibble_a: assert property (
      @(posedge clock) disable iff (!resetn)
      (good && exInput && exWidth == RION_PT4 && exNode[0]) |=>
         s_q.inWord[$past(wIdx)][7:4] == 4'h0
         && s_q.inWord[$past(wIdx)][15:8] == $past(s_q.inWord[wIdx][15:8]))
      else $error("four-point odd node mapped wrongly");
   gated_out_a: assert property (
      @(posedge clock) disable iff (!resetn)
      (exOutValid && exOutData != 16'h0000) |-> $past(exOk))
      else $error("output data sent without a good exchange");
   capacity_a: assert property (
      @(posedge clock) disable iff (!resetn)
      (rvalid && !$past(rvalid) && $past(araddr) == RION_OFS_INFO)
         |-> rdata[8:0] == (s_q.range16 ? RION_POINTS_16 : RION_POINTS_8))
      else $error("capacity does not follow node range");
   in_part_a: assert property (
      @(posedge clock) disable iff (!resetn)
      (good && exInput) |=> part[1][$past(exNode)] ##1 part[1][$past(exNode, 2)]
         || $past(s_q.restart))
      else $error("input slave participation not kept");
endmodule

// File: rtl/rion_pkg.sv
// remote i/o node map: shared constants and types
// assumes a 32-bit axi4-lite register bus and 16-bit i/o words
package rion_pkg;
   localparam int          RION_NODES      = 16;
   localparam int          RION_WORDS      = 8;
   localparam int          RION_AW         = 8;
   // register byte offsets
   localparam logic [7:0]  RION_OFS_CTRL   = 8'h00;
   localparam logic [7:0]  RION_OFS_STATUS = 8'h04;
   localparam logic [7:0]  RION_OFS_INFO   = 8'h08;
   localparam logic [7:0]  RION_OFS_PARTO  = 8'h0c;
   localparam logic [7:0]  RION_OFS_PARTI  = 8'h10;
   localparam logic [7:0]  RION_OFS_ERRO   = 8'h14;
   localparam logic [7:0]  RION_OFS_ERRI   = 8'h18;
   localparam logic [7:0]  RION_OFS_INW    = 8'h40;
   localparam logic [7:0]  RION_OFS_OUTW   = 8'h80;
   // field positions
   localparam int          RION_CTRL_RESTART = 0;
   localparam int          RION_ST_RANGE16   = 0;
   localparam int          RION_ST_UNITERR   = 1;
   localparam int          RION_ST_READY     = 2;
   localparam int          RION_INFO_WORDS   = 16;
   // capacity figures per node range
   localparam logic [8:0]  RION_POINTS_8   = 9'h080;
   localparam logic [8:0]  RION_POINTS_16  = 9'h100;
   localparam logic [4:0]  RION_WORDS_8    = 5'h0a;
   localparam logic [4:0]  RION_WORDS_16   = 5'h14;
   localparam logic [3:0]  RION_UNIT_MAX16 = 4'h8;
   // reset values and bus answers
   localparam logic [15:0] RION_RST_WORD   = 16'h0000;
   localparam logic [1:0]  RION_OKAY       = 2'h0;
   localparam logic [1:0]  RION_SLVERR     = 2'h2;
   typedef enum logic [1:0] {RION_PT4, RION_PT8, RION_PT16} rion_width_t;
endpackage

// File: testbench/rion_node_map_bench.sv
// node map bench: queue-free scoreboard of words and flags against the design
// assumes rion_slave_model on the scanner side and the package register map
`timescale 1ns/10ps
module rion_node_map_bench;
   import rion_pkg::*;
   logic              clock = 1'b0;
   logic              resetn = 1'b0;
   logic              rangeSel = 1'b1;
   logic [3:0]        unitNum = 4'h0;
   logic              exValid, exInput, exOk, exOutValid;
   logic [3:0]        exNode;
   rion_width_t       exWidth;
   logic [15:0]       exInData, exOutData;
   logic [7:0]        awaddr = 8'h00;
   logic [7:0]        araddr = 8'h00;
   logic [31:0]       wdata = 32'h0;
   logic [3:0]        wstrb = 4'h0;
   logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic              arvalid = 1'b0, rready = 1'b0;
   logic              awready, wready, bvalid, arready, rvalid;
   logic [1:0]        bresp, rresp, rsp;
   logic [31:0]       rdata, got;
   logic [15:0]       inW [8];
   logic [15:0]       outW [8];
   logic [15:0]       partI, partO, errI, errO;
   int                n_fail = 0;
   int                n_compared = 0;

   always #25 clock = ~clock;
   rion_slave_model slaves (.clock(clock), .exValid(exValid), .exInput(exInput),
      .exNode(exNode), .exWidth(exWidth), .exOk(exOk), .exInData(exInData));
   rion_node_map dut (.clock(clock), .resetn(resetn), .rangeSel(rangeSel),
      .unitNum(unitNum), .exValid(exValid), .exInput(exInput), .exNode(exNode),
      .exWidth(exWidth), .exOk(exOk), .exInData(exInData), .exOutValid(exOutValid),
      .exOutData(exOutData), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

   // ---------------------------------------------------------------
   // bus cycles, comparisons and the reference model
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
      chk({30'h0, g}, {30'h0, e});
   endtask
   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge clock);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do @(posedge clock); while (!(awready && wready));
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do @(posedge clock); while (!bvalid);
      rsp = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clock); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clock); while (!rvalid);
      got = rdata;
      rsp = rresp;
      rready <= 1'b0;
   endtask
   task automatic ex(input logic i, input logic [3:0] n, input rion_width_t w,
                     input logic ok, input logic [15:0] d, input logic acc);
      logic [15:0] m, e, o;
      m = (w == RION_PT16) ? 16'hffff : (n[0] ? 16'h00ff : 16'hff00);
      e = (w == RION_PT16) ? d : (w == RION_PT8) ? {d[7:0], d[7:0]} & m :
          {4'h0, d[3:0], 4'h0, d[3:0]} & m;
      o = outW[n[3:1]] & m;
      if (w != RION_PT16 && !n[0]) o = o >> 8;
      if (w == RION_PT4) o = o & 16'h000f;
      slaves.send(i, n, w, ok, d);
      if (acc && ok && i) inW[n[3:1]] = (inW[n[3:1]] & ~m) | e;
      if (acc && ok && i) begin
         partI[n] = 1'b1;
         errI[n] = 1'b0;
      end
      if (acc && ok && !i) begin
         partO[n] = 1'b1;
         errO[n] = 1'b0;
      end
      if (acc && !ok && i && partI[n]) errI[n] = 1'b1;
      if (acc && !ok && !i && partO[n]) errO[n] = 1'b1;
      #1;
      chk({31'h0, exOutValid}, {31'h0, acc && !i});
      if (acc && !i) chk({16'h0, exOutData}, {16'h0, ok ? o : 16'h0});
      @(posedge clock);
      #1;
      chk({31'h0, exOutValid}, 32'h0);
   endtask
   task automatic chk_words;
      for (int k = 0; k < 8; k++) begin
         rd(RION_OFS_INW + 8'(4 * k));
         chk(got, {16'h0, inW[k]});
         rd(RION_OFS_OUTW + 8'(4 * k));
         chk(got, {16'h0, outW[k]});
      end
   endtask
   task automatic chk_flags;
      logic [15:0] f [4];
      f = '{partO, partI, errO, errI};
      for (int k = 0; k < 4; k++) begin
         rd(RION_OFS_PARTO + 8'(4 * k));
         chk(got, {16'h0, f[k]});
         chk_resp(rsp, RION_OKAY);
      end
   endtask
   task automatic reset_dut(input logic r, input logic [3:0] u);
      @(posedge clock);
      resetn <= 1'b0;
      rangeSel <= r;
      unitNum <= u;
      repeat (16) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      {partI, partO, errI, errO} = 64'h0;
      for (int k = 0; k < 8; k++) begin
         inW[k] = 16'h0;
         outW[k] = 16'h0;
      end
   endtask

   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge clock);
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
      end_sim;
   end
   initial begin
      logic [31:0] r;
      void'($urandom(23));
      reset_dut(1'b1, 4'($urandom % 9));
      rd(RION_OFS_STATUS);
      chk(got, 32'h0000_0005);
      rd(RION_OFS_INFO);
      chk(got, 32'h0014_0100);
      rd(8'h3c);
      chk_resp(rsp, RION_SLVERR);
      chk(got, 32'h0);
      chk_flags;
      for (int k = 0; k < 8; k++) begin
         r = $urandom;
         wr(RION_OFS_OUTW + 8'(4 * k), r, 4'hf);
         chk_resp(rsp, RION_OKAY);
         outW[k] = r[15:0];
      end
      r = $urandom;
      wr(RION_OFS_OUTW, r, 4'h2);
      outW[0][15:8] = r[15:8];
      wr(8'h3c, $urandom, 4'hf);
      chk_resp(rsp, RION_SLVERR);
      wr(RION_OFS_INW, $urandom, 4'hf);
      chk_resp(rsp, RION_OKAY);
      ex(1'b0, 4'h5, RION_PT8, 1'b0, 16'h0, 1'b1);
      chk_flags;
      for (int w = 0; w < 3; w++) begin
         for (int n = 0; n < 16; n++) begin
            ex(1'b1, 4'(n), rion_width_t'(w), 1'b1, 16'($urandom), 1'b1);
            ex(1'b0, 4'(n), rion_width_t'(w), 1'b1, 16'($urandom), 1'b1);
         end
         chk_words;
      end
      rd(RION_OFS_INW + 8'h01);
      chk_resp(rsp, RION_SLVERR);
      chk(got, 32'h0);
      chk_flags;
      ex(1'b1, 4'hc, RION_PT8, 1'b0, 16'($urandom), 1'b1);
      ex(1'b0, 4'hc, RION_PT16, 1'b0, 16'h0, 1'b1);
      chk_flags;
      chk_words;
      wr(RION_OFS_CTRL, 32'h1, 4'hf);
      {partI, partO, errI, errO} = 64'h0;
      chk_flags;
      chk_words;
      reset_dut(1'b0, 4'($urandom));
      rd(RION_OFS_STATUS);
      chk(got, 32'h0000_0004);
      rd(RION_OFS_INFO);
      chk(got, 32'h000a_0080);
      ex(1'b1, 4'h9, RION_PT8, 1'b1, 16'($urandom), 1'b0);
      ex(1'b0, 4'h7, RION_PT4, 1'b1, 16'h0, 1'b1);
      chk_flags;
      reset_dut(1'b1, 4'(9 + $urandom % 7));
      rd(RION_OFS_STATUS);
      chk(got, 32'h0000_0007);
      ex(1'b0, 4'h1, RION_PT8, 1'b1, 16'h0, 1'b0);
      chk_flags;
      end_sim;
   end
endmodule

// File: testbench/rion_slave_model.sv
// remote i/o slaves as seen through the scanner's exchange reports
// assumes send is called from one process that runs in step with clock
`timescale 1ns/10ps
module rion_slave_model
   import rion_pkg::*;
(
   // clock
   input  wire logic                  clock,
   // exchange reports
   output logic                       exValid,
   output logic                       exInput,
   output logic [3:0]                 exNode,
   output rion_pkg::rion_width_t      exWidth,
   output logic                       exOk,
   output logic [15:0]                exInData
);
   logic                              req = 1'b0;
   logic                              rInp, rOk;
   logic [3:0]                        rNode;
   rion_width_t                       rWd;
   logic [15:0]                       rData;
   initial begin
      exValid = 1'b0;
      exInput = 1'b0;
      exNode = 4'h0;
      exWidth = RION_PT8;
      exOk = 1'b0;
      exInData = 16'h5a5a;
   end
   // ---------------------------------------------------------------
   // one report per request; node and data lines scramble between reports
   // ---------------------------------------------------------------
   always @(posedge clock) begin
      exValid <= req;
      if (req) begin
         exInput <= rInp;
         exNode <= rNode;
         exWidth <= rWd;
         exOk <= rOk;
         exInData <= rData;
         req = 1'b0;
      end else begin
         exInData <= ~exInData;
         exNode <= ~exNode;
      end
   end
   task automatic send(input logic i, input logic [3:0] n, input rion_width_t w,
                       input logic ok, input logic [15:0] d);
      @(negedge clock);
      rInp = i;
      rNode = n;
      rWd = w;
      rOk = ok;
      rData = d;
      req = 1'b1;
      @(posedge clock);
      @(posedge clock);
   endtask
endmodule
